// *** logic/erg_cfg.svh ***
// Constants of the event reset generator: register indices, fields, times.
// Assumes a 250 MHz core clock and an APB master with 32-bit data.
// Behaviour
// - Condition bit 7 chooses whether the event counts when active or inactive.
// - Condition bits 6..0 pick which event takes part in reset generation.
// - Three independent conditions qualify the reset together.
// - Config bit 7 low drives the output active low, high drives it active high.
// - Config bit 6 set ORs the external reset pin into the output.
// - Config bits 5..2 set hold time; zero is immediate, then 0.5 s/1 s steps.
// - Hold time counts only while every enabled condition holds at once.
// - Config bits 1..0 set pulse width: 500 us, 1 ms, 2 ms, 10 ms.
// - A condition register holding zero takes no part.
// - Level one means active event, level zero inactive event.
`ifndef ERG_CFG_SVH
`define ERG_CFG_SVH
`define ERG_IDX_COND1 8'h2B
`define ERG_IDX_COND2 8'h2C
`define ERG_IDX_COND3 8'h2D
`define ERG_IDX_CONFIG 8'h2E
`define ERG_IDX_STATUS 8'h3F
`define ERG_COND_LEVEL_BIT 7
`define ERG_CFG_POL_BIT 7
`define ERG_CFG_PASS_BIT 6
`define ERG_CLK_MHZ 250
`define ERG_HOLD_STEP_MS 500
`define ERG_WIDTH_STEP_US 500
`define ERG_HOLD_STEP_CYC (`ERG_HOLD_STEP_MS * 1000 * `ERG_CLK_MHZ)
`define ERG_WIDTH_STEP_CYC (`ERG_WIDTH_STEP_US * `ERG_CLK_MHZ)
`define ERG_REG_RESET 8'h00
`endif

// *** logic/erg_pkg.sv ***
// Types of the event reset generator.
// Assumes nothing beyond a SystemVerilog compiler.
package erg_pkg;
    typedef struct packed {
        logic level;
        logic [6:0] code;
    } erg_cond_t;
    typedef struct packed {
        logic pol;
        logic pass;
        logic [3:0] hold;
        logic [1:0] width;
    } erg_cfg_t;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_HOLD = 4'h2,
        ST_PULSE = 4'h4,
        ST_WAIT = 4'h8
    } erg_state_t;
endpackage

// *** logic/erg_top.sv ***
// Event reset generator: APB registers, condition match, hold timer, reset pulse.
// Assumes event levels and the external reset pin are asynchronous to I_CLK.
`include "erg_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module erg_top #(
    parameter int unsigned N_EVENTS = 128,
    parameter int unsigned HOLD_STEP_CYC = `ERG_HOLD_STEP_CYC,
    parameter int unsigned WIDTH_STEP_CYC = `ERG_WIDTH_STEP_CYC
) (
    input wire logic I_CLK,
    input wire logic I_SRST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    input wire logic [N_EVENTS-1:0] I_EVENT,
    input wire logic I_EXT_RST_N,
    output logic O_RESET_OUT
);
    // Hold time in 0.5 s steps
    function automatic logic [4:0] hold_steps(input logic [3:0] c);
        case (c)
            4'h0: hold_steps = 5'h00;
            4'h1: hold_steps = 5'h02;
            4'h2: hold_steps = 5'h03;
            4'h3: hold_steps = 5'h04;
            4'h4: hold_steps = 5'h05;
            4'h5: hold_steps = 5'h06;
            4'h6: hold_steps = 5'h07;
            4'h7: hold_steps = 5'h08;
            default: hold_steps = 5'({c, 1'b0} - 5'h06);
        endcase
    endfunction
    // Pulse width in 500 us steps
    function automatic logic [4:0] width_steps(input logic [1:0] c);
        case (c)
            2'h0: width_steps = 5'h01;
            2'h1: width_steps = 5'h02;
            2'h2: width_steps = 5'h04;
            default: width_steps = 5'h14;
        endcase
    endfunction

    // Synchronisers
    logic [N_EVENTS-1:0] ev_meta_ff, ev_sync_ff;
    logic ext_meta_ff, ext_sync_ff;
    always_ff @(posedge I_CLK) begin
        ev_meta_ff <= I_EVENT;
        ev_sync_ff <= ev_meta_ff;
        ext_meta_ff <= I_EXT_RST_N;
        ext_sync_ff <= ext_meta_ff;
    end

    // Registers and APB slave
    erg_pkg::erg_cond_t cond_ff [3];
    erg_pkg::erg_cond_t nxt_cond [3];
    erg_pkg::erg_cfg_t cfg_ff, nxt_cfg;
    logic [31:0] prdata_ff, nxt_prdata;
    logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
    erg_pkg::erg_state_t state_ff, nxt_state;
    logic all_ok;
    logic [5:0] idx;
    logic hit;
    logic [7:0] rd;
    always_comb begin
        nxt_cond = cond_ff;
        nxt_cfg = cfg_ff;
        idx = I_PADDR[7:2];
        hit = 1'b1;
        rd = 8'h00;
        case ({2'b00, idx})
            `ERG_IDX_COND1: rd = cond_ff[0];
            `ERG_IDX_COND2: rd = cond_ff[1];
            `ERG_IDX_COND3: rd = cond_ff[2];
            `ERG_IDX_CONFIG: rd = cfg_ff;
            `ERG_IDX_STATUS: rd = {3'h0, all_ok, state_ff};
            default: hit = 1'b0;
        endcase
        if (I_PADDR[1:0] != 2'h0) begin
            hit = 1'b0;
        end
        // One-wait-state answer, registered one cycle into the access phase
        nxt_pready = I_PSEL & I_PENABLE & ~pready_ff;
        nxt_pslverr = nxt_pready & ~hit;
        nxt_prdata = prdata_ff;
        if (nxt_pready) begin
            nxt_prdata = (hit && !I_PWRITE) ? {24'h000000, rd} : 32'h00000000;
        end
        if (I_PSEL && I_PENABLE && pready_ff && I_PWRITE && hit) begin
            case ({2'b00, idx})
                `ERG_IDX_COND1: nxt_cond[0] = I_PWDATA[7:0];
                `ERG_IDX_COND2: nxt_cond[1] = I_PWDATA[7:0];
                `ERG_IDX_COND3: nxt_cond[2] = I_PWDATA[7:0];
                `ERG_IDX_CONFIG: nxt_cfg = I_PWDATA[7:0];
                default: nxt_cfg = cfg_ff;
            endcase
        end
    end
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            for (int i = 0; i < 3; i++) begin
                cond_ff[i] <= `ERG_REG_RESET;
            end
            cfg_ff <= `ERG_REG_RESET;
            prdata_ff <= 32'h00000000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            cond_ff <= nxt_cond;
            cfg_ff <= nxt_cfg;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end
    assign O_PRDATA = prdata_ff;
    assign O_PREADY = pready_ff;
    assign O_PSLVERR = pslverr_ff;

    // Condition match
    logic [2:0] cond_en, cond_met;
    for (genvar g = 0; g < 3; g++) begin : g_cond
        assign cond_en[g] = (cond_ff[g] != `ERG_REG_RESET);
        assign cond_met[g] = ev_sync_ff[cond_ff[g].code] == cond_ff[g].level;
    end
    // No enabled condition means no trigger at all
    assign all_ok = (|cond_en) && ((cond_met | ~cond_en) == 3'h7);

    // Hold timer and pulse
    logic [31:0] cnt_ff, nxt_cnt, hold_lim, pulse_lim;
    assign hold_lim = 32'(hold_steps(cfg_ff.hold) * HOLD_STEP_CYC);
    assign pulse_lim = 32'(width_steps(cfg_ff.width) * WIDTH_STEP_CYC);
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        unique case (state_ff)
            erg_pkg::ST_IDLE: begin
                nxt_cnt = 32'h00000000;
                if (all_ok) begin
                    nxt_state = (cfg_ff.hold == 4'h0) ? erg_pkg::ST_PULSE : erg_pkg::ST_HOLD;
                end
            end
            erg_pkg::ST_HOLD: begin
                if (!all_ok) begin
                    nxt_state = erg_pkg::ST_IDLE;
                end else if (cnt_ff >= hold_lim - 32'h1) begin
                    nxt_state = erg_pkg::ST_PULSE;
                    nxt_cnt = 32'h00000000;
                end else begin
                    nxt_cnt = cnt_ff + 32'h1;
                end
            end
            erg_pkg::ST_PULSE: begin
                if (cnt_ff >= pulse_lim - 32'h1) begin
                    nxt_state = erg_pkg::ST_WAIT;
                end
                nxt_cnt = cnt_ff + 32'h1;
            end
            erg_pkg::ST_WAIT: begin
                // Stuck keys must not retrigger
                if (!all_ok) begin
                    nxt_state = erg_pkg::ST_IDLE;
                end
            end
            default: nxt_state = erg_pkg::ST_IDLE;
        endcase
    end
    logic out_ff, nxt_out, act;
    always_comb begin
        act = (state_ff == erg_pkg::ST_PULSE) | (cfg_ff.pass & ~ext_sync_ff);
        nxt_out = cfg_ff.pol ? act : ~act;
    end
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            state_ff <= erg_pkg::ST_IDLE;
            cnt_ff <= 32'h00000000;
            out_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            out_ff <= nxt_out;
        end
    end
    assign O_RESET_OUT = out_ff;

    property p_pol;
        @(posedge I_CLK) disable iff (I_SRST)
        (state_ff == erg_pkg::ST_PULSE) |=> (O_RESET_OUT == $past(cfg_ff.pol));
    endproperty
    a_pol: assert property (p_pol) else $error("Output polarity wrong in pulse");
    property p_pass;
        @(posedge I_CLK) disable iff (I_SRST)
        (cfg_ff.pass && !ext_sync_ff) |=> (O_RESET_OUT == $past(cfg_ff.pol));
    endproperty
    a_pass: assert property (p_pass) else $error("External reset not passed");
    property p_idle_out;
        @(posedge I_CLK) disable iff (I_SRST)
        (state_ff != erg_pkg::ST_PULSE && !cfg_ff.pass) |=> (O_RESET_OUT != $past(cfg_ff.pol));
    endproperty
    a_idle_out: assert property (p_idle_out) else $error("Output active without cause");
    property p_zero;
        @(posedge I_CLK) disable iff (I_SRST)
        (cond_en == 3'h0 && state_ff == erg_pkg::ST_IDLE) |=> (state_ff == erg_pkg::ST_IDLE);
    endproperty
    a_zero: assert property (p_zero) else $error("Disabled conditions triggered");
    property p_imm;
        @(posedge I_CLK) disable iff (I_SRST)
        (state_ff == erg_pkg::ST_IDLE && all_ok && cfg_ff.hold == 4'h0) |=> (state_ff == erg_pkg::ST_PULSE);
    endproperty
    a_imm: assert property (p_imm) else $error("Immediate trigger missed");
    property p_break;
        @(posedge I_CLK) disable iff (I_SRST)
        (state_ff == erg_pkg::ST_HOLD && !all_ok) |=> (state_ff == erg_pkg::ST_IDLE);
    endproperty
    a_break: assert property (p_break) else $error("Hold survived a released event");
    property p_sel;
        @(posedge I_CLK) disable iff (I_SRST)
        (cond_en[1] && ev_sync_ff[cond_ff[1].code] != cond_ff[1].level) |-> !all_ok;
    endproperty
    a_sel: assert property (p_sel) else $error("Selected event level ignored");
    property p_width;
        @(posedge I_CLK) disable iff (I_SRST)
        (state_ff == erg_pkg::ST_PULSE) |-> (cnt_ff < pulse_lim);
    endproperty
    a_width: assert property (p_width) else $error("Pulse longer than width");
    property p_rearm;
        @(posedge I_CLK) disable iff (I_SRST)
        (state_ff == erg_pkg::ST_WAIT && all_ok) |=> (state_ff == erg_pkg::ST_WAIT);
    endproperty
    a_rearm: assert property (p_rearm) else $error("Re-armed while held");
    c_hold: cover property (@(posedge I_CLK) state_ff == erg_pkg::ST_HOLD ##1 state_ff == erg_pkg::ST_PULSE);
    c_wait: cover property (@(posedge I_CLK) state_ff == erg_pkg::ST_WAIT ##1 state_ff == erg_pkg::ST_IDLE);
    c_err: cover property (@(posedge I_CLK) O_PSLVERR);
endmodule
`default_nettype wire

// *** verification/erg_host_model.sv ***
// Host side of the reset line: counts pulses and their widths.
// Assumes the bench tells it which level is active.
`timescale 1ns/1ns
`default_nettype none
module erg_host_model (
    input wire logic i_clk,
    input wire logic i_line,
    input wire logic i_act,
    output logic [31:0] o_pulses,
    output logic [31:0] o_width
);
    logic [31:0] run_ff = 32'h0;
    logic [31:0] pulses_ff = 32'h0;
    logic [31:0] width_ff = 32'h0;
    assign o_pulses = pulses_ff;
    assign o_width = width_ff;
    always @(posedge i_clk) begin
        if (i_line === i_act) begin
            run_ff <= run_ff + 32'h1;
        end else begin
            // Counted at the trailing edge, so width is exact
            if (run_ff != 32'h0) begin
                pulses_ff <= pulses_ff + 32'h1;
                width_ff <= run_ff;
            end
            run_ff <= 32'h0;
        end
    end
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
// Bench for erg_top: registers, event match, hold, pulse width, polarity.
// Assumes short time steps and the host model on the reset line.
`include "erg_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam int HS = 10;
    localparam int WS = 4;
    localparam logic [7:0] A2 = 8'(`ERG_IDX_COND2 * 4);
    localparam logic [7:0] A3 = 8'(`ERG_IDX_COND3 * 4);
    localparam logic [7:0] AC = 8'(`ERG_IDX_CONFIG * 4);
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd, np, nw, n0;
    logic pready, pslverr, se, rout;
    logic ext_n = 1'b1;
    logic act = 1'b0;
    logic [127:0] ev = '0;
    int err_total = 0;
    int comparisons = 0;
    int cyc = 0;
    always #2 clk = ~clk;
    erg_top #(.HOLD_STEP_CYC(HS), .WIDTH_STEP_CYC(WS)) u_dut (.I_CLK(clk), .I_SRST(srst), .I_PSEL(psel),
        .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .I_EVENT(ev), .I_EXT_RST_N(ext_n), .O_RESET_OUT(rout));
    erg_host_model u_host (.i_clk(clk), .i_line(rout), .i_act(act), .o_pulses(np), .o_width(nw));
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Waits for ready as long as it takes; only the global timeout ends a hang
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    // Polarity switch may leave a stray pulse; snapshot after it
    task automatic cfg(input logic [7:0] c);
        apb(1'b1, AC, c);
        act <= c[7];
        tick(4);
        n0 = np;
    endtask
    task automatic t_regs();
        logic [7:0] a[3] = '{A2, A3, AC};
        apb(1'b0, 8'(`ERG_IDX_STATUS * 4), 8'h00);
        chk("status idle", 32'h1, rd);
        foreach (a[i]) begin
            apb(1'b0, a[i], 8'h00);
            chk("reset value", 32'h0, rd);
            apb(1'b1, a[i], 8'hC1 + 8'(i));
            apb(1'b0, a[i], 8'h00);
            chk("readback", {24'h0, 8'hC1 + 8'(i)}, rd);
        end
        apb(1'b0, 8'hF4, 8'h00);
        chk("unmapped err", 32'h1, {31'h0, se});
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, A2 + 8'h1, 8'hFF);
        chk("misaligned err", 32'h1, {31'h0, se});
        apb(1'b0, A2, 8'h00);
        chk("misaligned ignored", 32'hC1, rd);
        apb(1'b1, A2, 8'h00);
        apb(1'b1, A3, 8'h00);
        cfg(8'h00);
        $display("regs done");
    endtask
    task automatic t_pass();
        logic [7:0] c[4] = '{8'h40, 8'h00, 8'hC0, 8'h80};
        foreach (c[i]) begin
            cfg(c[i]);
            ext_n <= 1'b0;
            tick(6);
            chk("ext low out", {31'h0, c[i][6] ~^ c[i][7]}, {31'h0, rout});
            ext_n <= 1'b1;
            tick(6);
            chk("idle out", {31'h0, ~c[i][7]}, {31'h0, rout});
        end
        $display("pass done");
    endtask
    task automatic t_level();
        cfg(8'h00);
        apb(1'b1, A2, 8'h05);
        tick(30);
        chk("pulses lvl0", n0 + 32'h1, np);
        chk("low width", 32'(WS), nw);
        ev[5] <= 1'b1;
        tick(10);
        ev[5] <= 1'b0;
        tick(30);
        chk("rearmed", n0 + 32'h2, np);
        apb(1'b1, A2, 8'h00);
        $display("level done");
    endtask
    task automatic t_width();
        int m[4] = '{1, 2, 4, 20};
        apb(1'b1, A2, 8'h85);
        // Zero registers would match event 0 low if they were not ignored
        ev[0] <= 1'b1;
        foreach (m[i]) begin
            cfg(8'h80 | 8'(i));
            ev[5] <= 1'b1;
            tick(130);
            chk("one pulse", n0 + 32'h1, np);
            chk("width", 32'(WS * m[i]), nw);
            ev[5] <= 1'b0;
            tick(5);
        end
        ev[0] <= 1'b0;
        $display("width done");
    endtask
    task automatic t_and();
        apb(1'b1, A3, 8'h89);
        cfg(8'h80);
        ev[5] <= 1'b1;
        tick(30);
        chk("one of two", n0, np);
        ev[9] <= 1'b1;
        tick(30);
        chk("both met", n0 + 32'h1, np);
        ev[5] <= 1'b0;
        ev[9] <= 1'b0;
        tick(5);
        apb(1'b1, A3, 8'h00);
        $display("and done");
    endtask
    task automatic t_hold();
        int hc[2] = '{1, 8};
        int hl[2] = '{2 * HS, 10 * HS};
        foreach (hc[i]) begin
            cfg(8'h80 | 8'(hc[i] << 2));
            ev[5] <= 1'b1;
            tick(hl[i] / 2);
            ev[5] <= 1'b0;
            tick(3);
            ev[5] <= 1'b1;
            tick(hl[i] - 2);
            chk("early", n0, np);
            chk("not yet", 32'h0, {31'h0, rout});
            tick(20);
            chk("after hold", n0 + 32'h1, np);
            ev[5] <= 1'b0;
            tick(5);
        end
        $display("hold done");
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            give_verdict();
        end
    end
    initial begin
        tick(10);
        srst <= 1'b0;
        t_regs();
        t_pass();
        t_level();
        t_width();
        t_and();
        t_hold();
        give_verdict();
    end
endmodule
`default_nettype wire
